// ---- bench/ccas_auto_shutdown_asserts.sv ----
`timescale 1ns/1ps
module ccas_auto_shutdown_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        tb_rollover,
  input wire logic        sync_in,
  input wire logic        sync_src_marked,
  input wire logic        sync_src_sync_mode,
  input wire logic        pwm_in,
  input wire logic        pwm_out,
  input wire logic        shutdown_event_flag
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    ##2 s_axi_bvalid;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> s_wr_answer)
    else $error("write response not on time");
  a_aw_ready_drop: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("awready stayed high");
  a_ar_ready_drop: assert property (s_axi_arvalid && s_axi_arready |=>
    !s_axi_arready) else $error("arready stayed high");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data not on time");
  a_b_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_pwm_gate_flag: assert property ($past(aresetn) && $past(aresetn, 2) |->
    pwm_out == ($past(pwm_in) && !$past(shutdown_event_flag)))
    else $error("pwm output not gated by flag");
  a_flag_fall_cause: assert property ($fell(shutdown_event_flag) |->
    $past(tb_rollover) || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)
    || $past(s_axi_bvalid, 3) || ($past(sync_in) && (!$past(sync_src_marked)
    || $past(sync_src_sync_mode))))
    else $error("flag cleared without a cause");
  c_flag_rise: cover property ($rose(shutdown_event_flag));
endmodule : ccas_auto_shutdown_asserts

// ---- bench/ccas_src_model.sv ----
`timescale 1ns/1ps
// Sources and time base answer one cycle after the request, like a
// registered comparator output would.
module ccas_src_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] src_req,
  input  wire logic       per_req,
  output logic      [7:0] shutdown_sources,
  output logic            tb_rollover
);
  always_ff @(posedge aclk) begin
    shutdown_sources <= aresetn ? src_req : 8'h00;
    tb_rollover      <= aresetn && per_req;
  end
endmodule : ccas_src_model

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
bind ccas_auto_shutdown ccas_auto_shutdown_asserts u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .tb_rollover, .sync_in, .sync_src_marked,
  .sync_src_sync_mode, .pwm_in, .pwm_out, .shutdown_event_flag);
module tb_top;
  import ccas_pkg::*;
  logic        aclk = 0, aresetn = 0, pwm_in = 0, per_req = 0, tb_rollover;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, src_req = 0;
  logic [7:0]  shutdown_sources;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, sync_in = 0;
  logic        sync_src_marked = 0, sync_src_sync_mode = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, pwm_out, shutdown_event_flag, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bresp_seen, r;
  int          failures = 0, samples_checked = 0;
  always #5 aclk = ~aclk;
  always @(posedge aclk) pwm_in <= ~pwm_in;
  ccas_src_model u_src (.aclk, .aresetn, .src_req, .per_req,
    .shutdown_sources, .tb_rollover);
  ccas_auto_shutdown u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .shutdown_sources, .tb_rollover, .sync_in,
    .sync_src_marked, .sync_src_sync_mode, .pwm_in, .pwm_out,
    .shutdown_event_flag, .irq);
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string w);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", w, exp, seen);
    end
  endtask : chk
  task nc(input int n);
    repeat (n) @(negedge aclk);
  endtask : nc
  // Valids drop only at the edge after ready was seen high, so a slow
  // slave is never cut short. Waits have no limit of their own; a hung
  // slave is caught by the watchdog.
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] dn;
    dn = 2'b00;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (dn != 2'b11) begin
      @(negedge aclk);
      dn = dn | {s_axi_awready === 1'b1, s_axi_wready === 1'b1};
      @(posedge aclk);
      if (dn[1]) s_axi_awvalid <= 1'b0;
      if (dn[0]) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    bresp_seen = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd
  task src(input logic [7:0] v);
    @(posedge aclk);
    src_req <= v;
  endtask : src
  task per;
    @(posedge aclk);
    per_req <= 1'b1;
    @(posedge aclk);
    per_req <= 1'b0;
  endtask : per
  task clr_flag(input logic exp);
    wr(CCAS_OFS_STATUS, 32'h0000_0001);
    nc(3);
    chk(shutdown_event_flag, exp, "flag after clear");
  endtask : clr_flag
  task t_regs;
    logic [7:0] ofs [4];
    ofs = '{CCAS_OFS_CTRL, CCAS_OFS_STATUS, CCAS_OFS_IRQ_STS, CCAS_OFS_IRQ_EN};
    foreach (ofs[i]) begin
      rd(ofs[i]);
      chk(d, 32'h0000_0000, "reset value");
    end
    wr(CCAS_OFS_CTRL, 32'hFFFF_FFFF);
    chk(bresp_seen, CCAS_RESP_OKAY, "mapped write resp");
    rd(CCAS_OFS_CTRL);
    chk(d, {16'h0000, CCAS_CTRL_MASK}, "ctrl readback");
    chk(r, CCAS_RESP_OKAY, "mapped read resp");
    @(posedge aclk);
    s_axi_wstrb <= 4'h1;
    wr(CCAS_OFS_CTRL, 32'h0000_0000);
    @(posedge aclk);
    s_axi_wstrb <= 4'hF;
    rd(CCAS_OFS_CTRL);
    chk(d, 32'h0000_D000, "ctrl byte strobe");
    wr(CCAS_OFS_CTRL, 32'h0000_0000);
    rd(8'h20);
    chk(d, 32'h0000_0000, "unmapped read data");
    chk(r, CCAS_RESP_SLVERR, "unmapped read resp");
    wr(8'h20, 32'h0000_0001);
    chk(bresp_seen, CCAS_RESP_SLVERR, "unmapped write");
    $display("test regs done");
  endtask : t_regs
  task t_sources;
    for (int i = 0; i < 8; i++) begin
      wr(CCAS_OFS_CTRL, 32'h1 << i);
      src(~(8'h01 << i));
      nc(4);
      chk(shutdown_event_flag, 1'b0, "disabled sources");
      src(8'h01 << i);
      nc(4);
      chk(shutdown_event_flag, 1'b1, "enabled source");
      src(8'h00);
      clr_flag(1'b0);
    end
    $display("test sources done");
  endtask : t_sources
  task t_hold;
    wr(CCAS_OFS_CTRL, 32'h0000_0001);
    src(8'h01);
    nc(4);
    src(8'h00);
    per();
    per();
    nc(3);
    chk(shutdown_event_flag, 1'b1, "flag held over periods");
    repeat (4) begin
      nc(1);
      chk(pwm_out, 1'b0, "pwm while shut down");
    end
    src(8'h01);
    nc(3);
    clr_flag(1'b1);
    src(8'h00);
    clr_flag(1'b0);
    chk(pwm_out, !pwm_in, "pwm after clear");
    $display("test hold done");
  endtask : t_hold
  task t_restart;
    wr(CCAS_OFS_CTRL, 32'h0000_8001);
    src(8'h01);
    nc(4);
    src(8'h00);
    clr_flag(1'b1);
    @(posedge aclk);
    sync_src_marked <= 1'b1;
    sync_in         <= 1'b1;
    @(posedge aclk);
    sync_in <= 1'b0;
    nc(3);
    chk(shutdown_event_flag, 1'b1, "marked sync unqualified");
    @(posedge aclk);
    sync_src_sync_mode <= 1'b1;
    sync_in            <= 1'b1;
    @(posedge aclk);
    sync_in <= 1'b0;
    nc(3);
    chk(shutdown_event_flag, 1'b0, "restart on period");
    rd(CCAS_OFS_IRQ_STS);
    chk(d[1], 1'b1, "restart event status");
    $display("test restart done");
  endtask : t_restart
  task t_defer;
    logic [31:0] mode [2];
    mode = '{32'h0000_4001, 32'h0000_5000};
    foreach (mode[i]) begin
      wr(CCAS_OFS_CTRL, mode[i]);
      src(mode[i][7:0]);
      nc(5);
      chk(shutdown_event_flag, 1'b0, "deferred shutdown");
      per();
      nc(3);
      chk(shutdown_event_flag, 1'b1, "shutdown at rollover");
      src(8'h00);
      wr(CCAS_OFS_CTRL, 32'h0000_0000);
      clr_flag(1'b0);
    end
    wr(CCAS_OFS_CTRL, 32'h0000_1000);
    nc(3);
    chk(shutdown_event_flag, 1'b1, "immediate force");
    wr(CCAS_OFS_CTRL, 32'h0000_0000);
    clr_flag(1'b0);
    $display("test defer done");
  endtask : t_defer
  task t_irq;
    wr(CCAS_OFS_IRQ_CLR, 32'h0000_0003);
    wr(CCAS_OFS_CTRL, 32'h0000_0001);
    src(8'h01);
    nc(4);
    chk(irq, 1'b0, "masked irq");
    rd(CCAS_OFS_IRQ_STS);
    chk(d[0], 1'b1, "set event status");
    wr(CCAS_OFS_IRQ_EN, 32'h0000_0001);
    nc(2);
    chk(irq, 1'b1, "enabled irq");
    wr(CCAS_OFS_IRQ_CLR, 32'h0000_0001);
    nc(2);
    chk(irq, 1'b0, "cleared irq");
    src(8'h00);
    clr_flag(1'b0);
    $display("test irq done");
  endtask : t_irq
  task finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    failures++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_sources();
    t_hold();
    t_restart();
    t_defer();
    t_irq();
    finish_test();
  end
endmodule : tb_top

// ---- rtl/ccas_auto_shutdown.sv ----
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module ccas_auto_shutdown
  import ccas_pkg::*;
#(
  parameter int NSRC = CCAS_NUM_SRC
)(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic [NSRC-1:0] shutdown_sources,
  input  wire logic            tb_rollover,
  input  wire logic            sync_in,
  input  wire logic            sync_src_marked,
  input  wire logic            sync_src_sync_mode,
  input  wire logic            pwm_in,
  output logic                 pwm_out,
  output logic                 shutdown_event_flag,
  output logic                 irq
);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == CCAS_OFS_CTRL) || (a == CCAS_OFS_STATUS) ||
             (a == CCAS_OFS_IRQ_STS) || (a == CCAS_OFS_IRQ_CLR) ||
             (a == CCAS_OFS_IRQ_EN);
  endfunction : mapped

  ccas_ctl_if #(.NSRC(NSRC)) cif ();

  logic [15:0]              ctrl_r, ctrl_nxt;
  logic [CCAS_NUM_IRQ-1:0]  ists_r, ists_nxt;
  logic [CCAS_NUM_IRQ-1:0]  ien_r, ien_nxt;
  logic                     aw_hold_r, aw_hold_nxt;
  logic                     w_hold_r, w_hold_nxt;
  logic [7:0]               awaddr_r, awaddr_nxt;
  logic [31:0]              wdata_r, wdata_nxt;
  logic [3:0]               wstrb_r, wstrb_nxt;
  logic                     awready_r, awready_nxt;
  logic                     wready_r, wready_nxt;
  logic                     bvalid_r, bvalid_nxt;
  logic [1:0]               bresp_r, bresp_nxt;
  logic                     arready_r, arready_nxt;
  logic                     rvalid_r, rvalid_nxt;
  logic [31:0]              rdata_r, rdata_nxt;
  logic [1:0]               rresp_r, rresp_nxt;
  logic                     clr_r, clr_nxt;
  logic                     pwm_r, pwm_nxt;
  logic                     irq_r, irq_nxt;
  logic                     do_wr;
  logic [31:0]              wmask;

  // A marked sync source is ignored unless its module runs synchronously.
  assign cif.period_strobe = tb_rollover |
    (sync_in & (~sync_src_marked | sync_src_sync_mode));
  assign cif.src_en     = ctrl_r[CCAS_SRC_LSB +: NSRC];
  assign cif.src_level  = shutdown_sources;
  assign cif.restart_en = ctrl_r[CCAS_BIT_RESTART];
  assign cif.defer_mode = ctrl_r[CCAS_BIT_DEFER];
  assign cif.sw_force   = ctrl_r[CCAS_BIT_FORCE];
  assign cif.sw_clear   = clr_r;

  ccas_event_core u_core (
    .aclk    (aclk),
    .aresetn (aresetn),
    .c       (cif)
  );

  always_comb begin
    wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
             {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    ctrl_nxt    = ctrl_r;
    ien_nxt     = ien_r;
    clr_nxt     = 1'b0;
    ists_nxt    = ists_r;
    if (s_axi_awvalid && awready_r) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_hold_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    do_wr = aw_hold_r && w_hold_r && !bvalid_r;
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = mapped(awaddr_r) ? CCAS_RESP_OKAY : CCAS_RESP_SLVERR;
      unique case (awaddr_r)
        CCAS_OFS_CTRL: begin
          ctrl_nxt = ((ctrl_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]))
                     & CCAS_CTRL_MASK;
        end
        CCAS_OFS_STATUS: begin
          clr_nxt = wdata_r[CCAS_BIT_FLAG] & wstrb_r[0];
        end
        CCAS_OFS_IRQ_CLR: begin
          if (wstrb_r[0]) begin
            ists_nxt = ists_r & ~wdata_r[CCAS_NUM_IRQ-1:0];
          end
        end
        CCAS_OFS_IRQ_EN: begin
          if (wstrb_r[0]) begin
            ien_nxt = wdata_r[CCAS_NUM_IRQ-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Hardware events win over a clear in the same cycle.
    if (cif.set_pulse) begin
      ists_nxt[CCAS_IRQ_SET] = 1'b1;
    end
    if (cif.restart_pulse) begin
      ists_nxt[CCAS_IRQ_RESTART] = 1'b1;
    end
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt  = !w_hold_nxt && !bvalid_nxt;
    irq_nxt     = |(ists_nxt & ien_nxt);
    // Shutdown drives the output inactive while the flag stands.
    pwm_nxt     = pwm_in & ~cif.flag;
  end

  always_comb begin
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = mapped(s_axi_araddr) ? CCAS_RESP_OKAY : CCAS_RESP_SLVERR;
      unique case (s_axi_araddr)
        CCAS_OFS_CTRL:    rdata_nxt = {16'h0000, ctrl_r};
        CCAS_OFS_STATUS:  rdata_nxt = {31'h00000000, cif.flag};
        CCAS_OFS_IRQ_STS: rdata_nxt = {30'h00000000, ists_r};
        CCAS_OFS_IRQ_EN:  rdata_nxt = {30'h00000000, ien_r};
        default:          rdata_nxt = 32'h00000000;
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r    <= CCAS_CTRL_RESET;
      ists_r    <= CCAS_IRQ_RESET;
      ien_r     <= CCAS_IRQ_RESET;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= CCAS_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= CCAS_RESP_OKAY;
      clr_r     <= 1'b0;
      pwm_r     <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      ists_r    <= ists_nxt;
      ien_r     <= ien_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      clr_r     <= clr_nxt;
      pwm_r     <= pwm_nxt;
      irq_r     <= irq_nxt;
    end
  end

  assign s_axi_awready       = awready_r;
  assign s_axi_wready        = wready_r;
  assign s_axi_bvalid        = bvalid_r;
  assign s_axi_bresp         = bresp_r;
  assign s_axi_arready       = arready_r;
  assign s_axi_rvalid        = rvalid_r;
  assign s_axi_rdata         = rdata_r;
  assign s_axi_rresp         = rresp_r;
  assign pwm_out             = pwm_r;
  assign shutdown_event_flag = cif.flag;
  assign irq                 = irq_r;

endmodule : ccas_auto_shutdown

// ---- rtl/ccas_ctl_if.sv ----
`timescale 1ns/1ps
interface ccas_ctl_if #(
  parameter int NSRC = 8
);
  logic [NSRC-1:0] src_en;
  logic [NSRC-1:0] src_level;
  logic            restart_en;
  logic            defer_mode;
  logic            sw_force;
  logic            sw_clear;
  logic            period_strobe;
  logic            flag;
  logic            set_pulse;
  logic            restart_pulse;

  modport core (
    input  src_en,
    input  src_level,
    input  restart_en,
    input  defer_mode,
    input  sw_force,
    input  sw_clear,
    input  period_strobe,
    output flag,
    output set_pulse,
    output restart_pulse
  );

  modport ctl (
    output src_en,
    output src_level,
    output restart_en,
    output defer_mode,
    output sw_force,
    output sw_clear,
    output period_strobe,
    input  flag,
    input  set_pulse,
    input  restart_pulse
  );
endinterface : ccas_ctl_if

// ---- rtl/ccas_event_core.sv ----
`timescale 1ns/1ps
module ccas_event_core
  import ccas_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  ccas_ctl_if.core  c
);

  logic flag_r;
  logic flag_nxt;
  logic ended_r;
  logic ended_nxt;
  logic set_r;
  logic set_nxt;
  logic rst_r;
  logic rst_nxt;
  logic trig;

  always_comb begin
    trig      = (|(c.src_level & c.src_en)) | c.sw_force;
    flag_nxt  = flag_r;
    ended_nxt = ended_r;
    set_nxt   = 1'b0;
    rst_nxt   = 1'b0;
    if (!flag_r) begin
      ended_nxt = 1'b0;
      // Deferred mode waits for the time base to restart the period.
      if (trig && (!c.defer_mode || c.period_strobe)) begin
        flag_nxt = 1'b1;
        set_nxt  = 1'b1;
      end
    end else if (c.restart_en) begin
      if (trig) begin
        ended_nxt = 1'b0;
      end else if (!ended_r) begin
        ended_nxt = 1'b1;
      end else if (c.period_strobe) begin
        // Input gone for a full cycle before the new period begins.
        flag_nxt  = 1'b0;
        ended_nxt = 1'b0;
        rst_nxt   = 1'b1;
      end
    end else if (c.sw_clear && !trig) begin
      // A trigger still present keeps the flag: the set wins.
      flag_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r  <= 1'b0;
      ended_r <= 1'b0;
      set_r   <= 1'b0;
      rst_r   <= 1'b0;
    end else begin
      flag_r  <= flag_nxt;
      ended_r <= ended_nxt;
      set_r   <= set_nxt;
      rst_r   <= rst_nxt;
    end
  end

  assign c.flag          = flag_r;
  assign c.set_pulse     = set_r;
  assign c.restart_pulse = rst_r;

endmodule : ccas_event_core

// ---- rtl/ccas_pkg.sv ----
package ccas_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] CCAS_OFS_CTRL    = 8'h00;
  localparam logic [7:0] CCAS_OFS_STATUS  = 8'h04;
  localparam logic [7:0] CCAS_OFS_IRQ_STS = 8'h08;
  localparam logic [7:0] CCAS_OFS_IRQ_CLR = 8'h0C;
  localparam logic [7:0] CCAS_OFS_IRQ_EN  = 8'h10;

  // Field positions in capture_compare_control_one_high.
  localparam int CCAS_BIT_RESTART = 15;
  localparam int CCAS_BIT_DEFER   = 14;
  localparam int CCAS_BIT_FORCE   = 12;
  localparam int CCAS_SRC_LSB     = 0;
  localparam int CCAS_NUM_SRC     = 8;

  // Writable bits of the control register; all others read as zero.
  localparam logic [15:0] CCAS_CTRL_MASK  = 16'hD0FF;
  localparam logic [15:0] CCAS_CTRL_RESET = 16'h0000;

  // Status register: bit 0 is the event flag, write one to clear; the write is ignored while restart (bit 15 of control) is set.
  localparam int CCAS_BIT_FLAG = 0;

  // Interrupt sources.
  localparam int CCAS_IRQ_SET     = 0;
  localparam int CCAS_IRQ_RESTART = 1;
  localparam int CCAS_NUM_IRQ     = 2;
  localparam logic [1:0] CCAS_IRQ_RESET = 2'h0;

  localparam logic [1:0] CCAS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CCAS_RESP_SLVERR = 2'h2;

endpackage : ccas_pkg
